// ==== logic/power_reset_control.v ====
// Power and reset control: sleep mode, peripheral clock gating, reset combining.
// Assumes an APB master on ref_clk and analog detectors giving digital levels.
//
// Operation
// RQ1 - Decode three-bit sleep select into six modes, two codes reserved
// RQ2 - Software picks standby codes only with crystal clock
// RQ3 - Sleep instruction sleeps only while sleep-enable bit is one
// RQ4 - Software sets sleep-enable just before sleep, clears after wake
// RQ5 - First register bit 7 stops two-wire interface clock
// RQ6 - Bit 6 stops timer two only when its async select is zero
// RQ7 - Bits 5 and 3 stop timer zero and timer one
// RQ8 - Bits 2 and 1 stop serial peripheral and serial port zero clocks
// RQ9 - Bit 0 stops converter; comparator loses converter input mux then
// RQ10 - First register bit 4, second bits 7:6 read zero
// RQ11 - Second register bits 5,4,3 stop timers five, four, three
// RQ12 - Second register bits 2,1,0 stop serial ports three, two, one
// RQ13 - Reset loads every register with its initial value
// RQ14 - Ports reset at once when any source active, no clock needed
// RQ15 - Delay counter stretches internal reset after all sources release
// RQ16 - Five sources combined; scan reset holds while its bit is one
// RQ17 - Power-on starts delay; supply drop reasserts reset at once
// RQ18 - External pin low resets without clock; rise starts delay
// RQ19 - Brown-out asserts reset at once, release starts delay
// RQ20 - Brown-out ignores drops shorter than minimum detection time
// RQ21 - Watchdog gives one-cycle pulse; delay starts at its fall
// RQ22 - Bandgap on only for brown-out, comparator select, or converter
// RQ23 - Gated peripheral frozen, its registers inaccessible, restored later
// RQ24 - Gate enables change only on a clock boundary
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "power_reset_regs.vh"

module power_reset_control #(
   parameter CNT_W      = 20,
   parameter TOUT_CYC   = `TOUT_DEFAULT,
   parameter BOD_CYC    = `BOD_MIN_CYC
) (
   input  wire             ref_clk,
   input  wire             rst_n,
   input  wire             clk_en,
   // APB slave
   input  wire             psel,
   input  wire             penable,
   input  wire             pwrite,
   input  wire [11:0]      paddr,
   input  wire [31:0]      pwdata,
   output wire             pready,
   output reg  [31:0]      prdata,
   output wire             pslverr,
   // Core and analog side
   input  wire             sleep_instr,
   input  wire             power_good,
   input  wire             ext_reset_n,
   input  wire             wdt_timeout,
   input  wire             brownout_enable,
   input  wire             brownout_low,
   input  wire             scan_reset,
   input  wire             timer_two_async_select,
   input  wire             comparator_bandgap_select,
   input  wire             converter_enable,
   input  wire [CNT_W-1:0] startup_cycles,
   input  wire [13:0]      periph_access,
   output reg              sleep_req,
   output reg  [2:0]       sleep_mode,
   output reg              mode_reserved,
   output wire             int_reset_n,
   output wire             port_reset_n,
   output wire             wdt_reset_pulse,
   output wire             bandgap_on,
   output wire             comparator_mux_allow,
   output wire [13:0]      gate_enable,
   output wire [13:0]      gated_clk,
   output wire [13:0]      periph_access_ok
);

   // ****************************************
   // Helpers
   // ****************************************
   function is_reserved;
      input [2:0] code;
      begin
         is_reserved = (code == 3'h4) || (code == 3'h5);   // RQ1
      end
   endfunction

   reg  [7:0]       power_reduction_first_r;
   reg  [7:0]       power_reduction_second_r;
   reg  [7:0]       sleep_mode_control_r;
   reg              bod_s1_r;
   reg              bod_s2_r;
   reg  [15:0]      bod_cnt_r;
   reg              bod_trip_r;
   reg              wdt_s1_r;
   reg              wdt_s2_r;
   reg              wdt_d_r;
   reg              wdt_pulse_r;
   reg  [CNT_W-1:0] tout_r;

   wire             wr_en;
   wire             rd_en;
   wire             raw_reset;
   wire             sleep_enable_bit;
   wire [2:0]       sleep_mode_select;
   wire             gate_two_wire_if;
   wire             gate_timer_two;
   wire             gate_timer_zero;
   wire             gate_timer_one;
   wire             gate_serial_periph;
   wire             gate_serial_port_zero;
   wire             gate_converter;
   wire             gate_timer_five;
   wire             gate_timer_four;
   wire             gate_timer_three;
   wire             gate_serial_port_three;
   wire             gate_serial_port_two;
   wire             gate_serial_port_one;
   wire [13:0]      gate_off;

   // ****************************************
   // APB strobes
   // ****************************************
   assign wr_en   = psel & penable & pwrite & clk_en;
   assign rd_en   = psel & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Register writes; reserved bits masked so they never store
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_reduction_first_r  <= `RESET_VAL_8;               // RQ13
         power_reduction_second_r <= `RESET_VAL_8;
         sleep_mode_control_r     <= `RESET_VAL_8;
         tout_r                   <= TOUT_CYC[CNT_W-1:0];
      end else if (wr_en) begin
         case (paddr)
            `ADDR_PRR_FIRST: begin
               power_reduction_first_r <= pwdata[7:0] & `PRR_FIRST_MASK;    // RQ10
            end
            `ADDR_PRR_SECOND: begin
               power_reduction_second_r <= pwdata[7:0] & `PRR_SECOND_MASK;  // RQ10
            end
            `ADDR_SLEEP_CTRL: begin
               sleep_mode_control_r <= pwdata[7:0] & `SLEEP_CTRL_MASK;
            end
            `ADDR_CONFIG: begin
               tout_r <= pwdata[CNT_W-1:0];
            end
            default: begin
               tout_r <= tout_r;
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         case (paddr)
            `ADDR_PRR_FIRST:   prdata = {24'h000000, power_reduction_first_r};
            `ADDR_PRR_SECOND:  prdata = {24'h000000, power_reduction_second_r};
            `ADDR_SLEEP_CTRL:  prdata = {24'h000000, sleep_mode_control_r};
            `ADDR_STATUS:      prdata = {26'h0000000, bandgap_on, bod_trip_r,
                                         mode_reserved, sleep_req, ~int_reset_n,
                                         wdt_pulse_r};
            `ADDR_CONFIG:      prdata = {{(32-CNT_W){1'b0}}, tout_r};
            default:           prdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Sleep control
   // ****************************************
   assign sleep_enable_bit  = sleep_mode_control_r[`SE_BIT];
   assign sleep_mode_select = sleep_mode_control_r[`SM_MSB:`SM_LSB];

   // Sleep request registered; reserved codes never enter sleep
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_req     <= 1'b0;
         sleep_mode    <= `SM_IDLE;
         mode_reserved <= 1'b0;
      end else if (clk_en) begin
         sleep_mode    <= sleep_mode_select;                        // RQ1
         mode_reserved <= is_reserved(sleep_mode_select);
         sleep_req     <= sleep_instr & sleep_enable_bit &
                          ~is_reserved(sleep_mode_select);          // RQ3
      end
   end

   // ****************************************
   // Peripheral clock gating
   // ****************************************
   assign gate_two_wire_if       = power_reduction_first_r[7];      // RQ5
   assign gate_timer_two         = power_reduction_first_r[`TIM2_BIT] &
                                   ~timer_two_async_select;         // RQ6
   assign gate_timer_zero        = power_reduction_first_r[5];      // RQ7
   assign gate_timer_one         = power_reduction_first_r[3];      // RQ7
   assign gate_serial_periph     = power_reduction_first_r[2];      // RQ8
   assign gate_serial_port_zero  = power_reduction_first_r[1];      // RQ8
   assign gate_converter         = power_reduction_first_r[`CONV_BIT]; // RQ9
   assign gate_timer_five        = power_reduction_second_r[5];     // RQ11
   assign gate_timer_four        = power_reduction_second_r[4];     // RQ11
   assign gate_timer_three       = power_reduction_second_r[3];     // RQ11
   assign gate_serial_port_three = power_reduction_second_r[2];     // RQ12
   assign gate_serial_port_two   = power_reduction_second_r[1];     // RQ12
   assign gate_serial_port_one   = power_reduction_second_r[0];     // RQ12

   assign gate_off = {gate_serial_port_one, gate_serial_port_two, gate_serial_port_three,
                      gate_timer_three, gate_timer_four, gate_timer_five,
                      gate_converter, gate_serial_port_zero, gate_serial_periph,
                      gate_timer_one, 1'b0, gate_timer_zero, gate_timer_two,
                      gate_two_wire_if};

   // Frozen peripheral: no clock and no register access
   assign gate_enable          = ~gate_off;                                  // RQ23
   assign periph_access_ok     = periph_access & ~gate_off;                  // RQ23
   assign comparator_mux_allow = ~gate_converter;                            // RQ9

   clock_gate_cell #(
      .N         (14)
   ) u_gate (
      .ref_clk   (ref_clk),
      .enable    (gate_enable),
      .gated_clk (gated_clk)
   );

   // ****************************************
   // Brown-out filter
   // ****************************************
   // Short spikes under the trigger level are ignored
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bod_s1_r   <= 1'b0;
         bod_s2_r   <= 1'b0;
         bod_cnt_r  <= 16'h0000;
         bod_trip_r <= 1'b0;
      end else if (clk_en) begin
         bod_s1_r <= brownout_low;
         bod_s2_r <= bod_s1_r;
         if (bod_s2_r && brownout_enable) begin
            if (bod_cnt_r >= BOD_CYC[15:0] - 16'h0001) begin
               bod_trip_r <= 1'b1;                                  // RQ20
            end else begin
               bod_cnt_r <= bod_cnt_r + 16'h0001;
            end
         end else begin
            bod_cnt_r  <= 16'h0000;
            bod_trip_r <= 1'b0;                                     // RQ19
         end
      end
   end

   // ****************************************
   // Watchdog one-cycle pulse
   // ****************************************
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_s1_r    <= 1'b0;
         wdt_s2_r    <= 1'b0;
         wdt_d_r     <= 1'b0;
         wdt_pulse_r <= 1'b0;
      end else if (clk_en) begin
         wdt_s1_r    <= wdt_timeout;
         wdt_s2_r    <= wdt_s1_r;
         wdt_d_r     <= wdt_s2_r;
         wdt_pulse_r <= wdt_s2_r & ~wdt_d_r;                        // RQ21
      end
   end
   assign wdt_reset_pulse = wdt_pulse_r;

   // ****************************************
   // Reset combining
   // ****************************************
   // Pin and power paths are combinational so they act with no clock
   assign raw_reset = ~rst_n | ~power_good                          // RQ17
                    | ~ext_reset_n                                  // RQ18
                    | wdt_pulse_r                                   // RQ21
                    | (bod_trip_r & brownout_enable)                // RQ19
                    | scan_reset;                                   // RQ16

   assign port_reset_n = ~raw_reset;                                // RQ14

   // Fuse-derived time-out when nonzero, else the software config value
   reset_stretch #(
      .CNT_W          (CNT_W)
   ) u_stretch (
      .ref_clk        (ref_clk),
      .raw_reset      (raw_reset),
      .clk_en         (clk_en),
      .timeout_cycles ((startup_cycles != {CNT_W{1'b0}}) ? startup_cycles : tout_r), // RQ15
      .int_reset_n    (int_reset_n)
   );

   // ****************************************
   // Bandgap enable
   // ****************************************
   assign bandgap_on = brownout_enable | comparator_bandgap_select |
                       converter_enable;                            // RQ22

endmodule
`default_nettype wire

// ==== logic/power_reset_regs.vh ====
// Register map, field positions and timing constants for power and reset control.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef POWER_RESET_REGS_VH
`define POWER_RESET_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_PRR_FIRST     12'h064
`define ADDR_SLEEP_CTRL    12'h068
`define ADDR_PRR_SECOND    12'h06C
`define ADDR_STATUS        12'h070
`define ADDR_CONFIG        12'h074

// ****************************************
// Field positions and masks
// ****************************************
`define PRR_FIRST_MASK     8'hEF
`define PRR_SECOND_MASK    8'h3F
`define SLEEP_CTRL_MASK    8'h0F
`define SE_BIT             0
`define SM_LSB             1
`define SM_MSB             3
`define TIM2_BIT           6
`define CONV_BIT           0
`define RESET_VAL_8        8'h00

// ****************************************
// Sleep mode codes
// ****************************************
`define SM_IDLE            3'h0
`define SM_NOISE_RED       3'h1
`define SM_POWER_DOWN      3'h2
`define SM_POWER_SAVE      3'h3
`define SM_STANDBY         3'h6
`define SM_EXT_STANDBY     3'h7

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS      20
`define BOD_MIN_NS         2000
`define BOD_MIN_CYC        ((`BOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOUT_DEFAULT       65536

`endif

// ==== logic/reset_stretch.v ====
// Delay counter that stretches the internal reset after all sources release.
// Assumes raw_reset is asynchronous-safe active-high from the combiner.
`timescale 1ns/1ns
`default_nettype none

module reset_stretch #(
   parameter CNT_W = 20
) (
   input  wire             ref_clk,
   input  wire             raw_reset,
   input  wire             clk_en,
   input  wire [CNT_W-1:0] timeout_cycles,
   output wire             int_reset_n
);

   reg  [CNT_W-1:0] count_r;
   reg              hold_r;
   reg              sync1_r;
   reg              sync2_r;

   // ****************************************
   // Release synchroniser; assertion is immediate
   // ****************************************
   always @(posedge ref_clk or posedge raw_reset) begin
      if (raw_reset) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else if (clk_en) begin
         sync1_r <= 1'b1;
         sync2_r <= sync1_r;
      end
   end

   // Counts only once every source is gone, so a reassertion restarts it
   always @(posedge ref_clk or posedge raw_reset) begin
      if (raw_reset) begin
         count_r <= {CNT_W{1'b0}};
         hold_r  <= 1'b1;
      end else if (clk_en && sync2_r && hold_r) begin
         if (count_r >= timeout_cycles - 1'b1) begin
            hold_r <= 1'b0;                          // RQ15
         end else begin
            count_r <= count_r + 1'b1;
         end
      end
   end

   assign int_reset_n = ~hold_r & ~raw_reset;       // RQ17

endmodule
`default_nettype wire

// ==== logic/clock_gate_cell.v ====
// Glitch-free clock gate: enable latched while the clock is low.
// Assumes ref_clk is the free-running system clock.
`timescale 1ns/1ns
`default_nettype none

module clock_gate_cell #(
   parameter N = 14
) (
   input  wire         ref_clk,
   input  wire [N-1:0] enable,
   output wire [N-1:0] gated_clk
);

   reg [N-1:0] en_lat;

   // ****************************************
   // Latch transparent in the low phase
   // ****************************************
   always @* begin
      if (!ref_clk) begin
         en_lat = enable;
      end else begin
         en_lat = en_lat;
      end
   end

   // No truncated pulse: enable only changes while clock is low
   assign gated_clk = {N{ref_clk}} & en_lat;        // RQ24

endmodule
`default_nettype wire

// ==== verification/power_reset_checker.sv ====
// Checker for power and reset control: watches the top module's ports only.
// Assumes one clock domain on ref_clk and rst_n as asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module power_reset_checker #(
   parameter CNT_W = 20
) (
   input wire logic             ref_clk,
   input wire logic             rst_n,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic             sleep_instr,
   input wire logic             sleep_req,
   input wire logic [2:0]       sleep_mode,
   input wire logic             mode_reserved,
   input wire logic             power_good,
   input wire logic             ext_reset_n,
   input wire logic             scan_reset,
   input wire logic             wdt_timeout,
   input wire logic             wdt_reset_pulse,
   input wire logic             port_reset_n,
   input wire logic             int_reset_n,
   input wire logic [CNT_W-1:0] startup_cycles,
   input wire logic             brownout_enable,
   input wire logic             comparator_bandgap_select,
   input wire logic             converter_enable,
   input wire logic             bandgap_on,
   input wire logic             comparator_mux_allow,
   input wire logic             timer_two_async_select,
   input wire logic [13:0]      gate_enable,
   input wire logic [13:0]      periph_access,
   input wire logic [13:0]      periph_access_ok
);
   // ****************************************
   // Helper count and properties
   // ****************************************
   logic [7:0] hi_cnt_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Cycles since all sources released; saturates so it never wraps
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) hi_cnt_r <= 8'h00;
      else if (!port_reset_n || wdt_reset_pulse) hi_cnt_r <= 8'h00;
      else if (hi_cnt_r != 8'hFF) hi_cnt_r <= hi_cnt_r + 8'h01;
   end
   apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
      else $error("apb access not answered cleanly");
   mode_flag_a: assert property (mode_reserved == (sleep_mode[2:1] == 2'b10))
      else $error("reserved mode flag wrong");
   sleep_gate_a: assert property (sleep_req |-> !mode_reserved && $past(sleep_instr))
      else $error("sleep request without cause");
   src_reset_a: assert property (!power_good || !ext_reset_n || scan_reset
      |-> !port_reset_n && !int_reset_n) else $error("reset source not honoured");
   wdt_single_a: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
      else $error("watchdog pulse longer than one cycle");
   wdt_seen_a: assert property ($rose(wdt_timeout) |-> ##[1:4] wdt_reset_pulse)
      else $error("watchdog pulse missing");
   stretch_min_a: assert property ($rose(int_reset_n) |-> hi_cnt_r >= startup_cycles)
      else $error("internal reset released early");
   stretch_max_a: assert property (hi_cnt_r == startup_cycles + 6 |-> int_reset_n)
      else $error("internal reset held too long");
   gate_fixed_a: assert property (gate_enable[3]
      && (!timer_two_async_select || gate_enable[1])) else $error("gate map wrong");
   access_mask_a: assert property (periph_access_ok == (periph_access & gate_enable))
      else $error("gated peripheral reachable");
   bandgap_on_a: assert property (bandgap_on
      == (brownout_enable || comparator_bandgap_select || converter_enable))
      else $error("bandgap power wrong");
   mux_allow_a: assert property (comparator_mux_allow == gate_enable[7])
      else $error("comparator mux permission wrong");
endmodule
`default_nettype wire

// ==== verification/periph_model.sv ====
// Peripheral-side model: one tick counter behind each gated clock.
// Assumes gated_clk comes from the block's gates and rst_n is async low.
`timescale 1ns/1ns
`default_nettype none
module periph_model (
   input  wire logic        rst_n,
   input  wire logic [13:0] gated_clk,
   output var  logic [55:0] ticks
);
   genvar i;
   // A stopped clock freezes the count; reopening resumes where it was
   for (i = 0; i < 14; i = i + 1) begin : g_tick
      always @(posedge gated_clk[i] or negedge rst_n) begin
         if (!rst_n) ticks[4*i+:4] <= 4'h0;
         else ticks[4*i+:4] <= ticks[4*i+:4] + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== verification/power_reset_control_bench.sv ====
// Self-checking bench for power and reset control with a peripheral model.
// Assumes the register header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "power_reset_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module power_reset_control_bench;
   // ****************************************
   // Signals, tasks and scoreboard
   // ****************************************
   logic        ref_clk, rst_n, clk_en, psel, penable, pwrite, sleep_instr, power_good;
   logic        ext_reset_n, wdt_timeout, brownout_enable, brownout_low, scan_reset;
   logic        timer_two_async_select, comparator_bandgap_select, converter_enable;
   logic        pready, pslverr, sleep_req, mode_reserved, int_reset_n, port_reset_n;
   logic        wdt_reset_pulse, bandgap_on, comparator_mux_allow, ok;
   logic [2:0]  sleep_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic [31:0] seed = 32'h6823A308;
   logic [13:0] periph_access, gate_enable, gated_clk, periph_access_ok, ge;
   logic [55:0] ticks, t0;
   logic [63:0] exp_q[$];
   logic [63:0] obs, e;
   int          n_fail = 0, n_compared = 0, obs_id = 0, seen_id = 0, i, k, c;
   logic [11:0] adr[4] = '{`ADDR_PRR_FIRST, `ADDR_SLEEP_CTRL, `ADDR_PRR_SECOND, 12'h080};
   logic [31:0] msk[4] = '{32'h000000EF, 32'h0000000F, 32'h0000003F, 32'h00000000};
   power_reset_control #(.TOUT_CYC(16), .BOD_CYC(4)) dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sleep_instr(sleep_instr), .power_good(power_good),
      .ext_reset_n(ext_reset_n), .wdt_timeout(wdt_timeout),
      .brownout_enable(brownout_enable), .brownout_low(brownout_low),
      .scan_reset(scan_reset), .timer_two_async_select(timer_two_async_select),
      .comparator_bandgap_select(comparator_bandgap_select),
      .converter_enable(converter_enable), .startup_cycles(20'h00010),
      .periph_access(periph_access), .sleep_req(sleep_req), .sleep_mode(sleep_mode),
      .mode_reserved(mode_reserved), .int_reset_n(int_reset_n),
      .port_reset_n(port_reset_n), .wdt_reset_pulse(wdt_reset_pulse),
      .bandgap_on(bandgap_on), .comparator_mux_allow(comparator_mux_allow),
      .gate_enable(gate_enable), .gated_clk(gated_clk),
      .periph_access_ok(periph_access_ok));
   periph_model far (.rst_n(rst_n), .gated_clk(gated_clk), .ticks(ticks));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Gate map: low eight bits from first register except fixed bit 3, timer two kept while async
   function automatic logic [13:0] gexp(logic [7:0] f, logic [7:0] s, logic as);
      return {~s[0], ~s[1], ~s[2], ~s[3], ~s[4], ~s[5], ~f[0], ~f[1], ~f[2], ~f[3],
              1'b1, ~f[5], ~(f[6] & ~as), ~f[7]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic complete_run;
      $display("counts compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Idle edge first, so back-to-back calls never reassign psel at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin n_fail++; complete_run; end
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic note(input logic [63:0] ex, input logic [63:0] got);
      exp_q.push_back(ex);
      obs <= got;
      obs_id <= obs_id + 1;
      @(posedge ref_clk);
   endtask
   task automatic wait_int(output int n);
      for (n = 0; n < 300; n++) begin
         if (int_reset_n === 1'b1) break;
         @(posedge ref_clk);
      end
      if (n == 300) begin n_fail++; complete_run; end
   endtask
   // Observer takes the oldest note whenever a new result is posted
   always @(posedge ref_clk) begin
      if (obs_id != seen_id) begin
         seen_id = obs_id;
         e = exp_q.pop_front();
         `CHK(obs, e)
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      rst_n = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      sleep_instr = 0; power_good = 1; ext_reset_n = 1; wdt_timeout = 0; scan_reset = 0;
      brownout_enable = 0; brownout_low = 0; timer_two_async_select = 0;
      comparator_bandgap_select = 0; converter_enable = 0; periph_access = 0;
      tick(20);
      rst_n <= 1'b1;
      wait_int(c);
      for (i = 0; i < 4; i++) begin apb(0, adr[i], 0, rd); note(0, rd); end
      for (i = 0; i < 4; i++) begin
         apb(1, adr[i], 32'hFFFFFFFF, rd);
         apb(0, adr[i], 0, rd);
         note(msk[i], rd);
      end
      clk_en <= 1'b0;
      apb(1, `ADDR_PRR_FIRST, 32'h1, rd);
      clk_en <= 1'b1;
      apb(0, `ADDR_PRR_FIRST, 0, rd);
      note(32'hEF, rd);
      $display("registers test done");
      for (i = 0; i < 12; i++) begin
         r = xs();
         periph_access <= r[13:0];
         {brownout_enable, comparator_bandgap_select, converter_enable} <= r[18:16];
         apb(1, `ADDR_PRR_FIRST, r[31:24], rd);
         apb(1, `ADDR_PRR_SECOND, r[23:16], rd);
         tick(3);
         ge = gexp(r[31:24], r[23:16], 1'b0);
         note(ge, gate_enable);
         @(negedge ref_clk) t0 = ticks;
         repeat (4) @(negedge ref_clk);
         for (k = 0; k < 14; k++) t0[4*k+:4] = t0[4*k+:4] + (ge[k] ? 4'h4 : 4'h0);
         note(t0, ticks);
      end
      timer_two_async_select <= 1'b1;
      apb(1, `ADDR_PRR_FIRST, 32'h40, rd);
      tick(3);
      note(1, gate_enable[1]);
      timer_two_async_select <= 1'b0;
      tick(3);
      note(0, gate_enable[1]);
      $display("gating test done");
      for (i = 0; i < 16; i++) begin
         apb(1, `ADDR_SLEEP_CTRL, i, rd);
         sleep_instr <= 1'b1;
         tick(2);
         ok = (i[3:1] == 3'h4) || (i[3:1] == 3'h5);
         note({i[3:1], ok, i[0] & ~ok}, {sleep_mode, mode_reserved, sleep_req});
         sleep_instr <= 1'b0;
      end
      $display("sleep test done");
      rst_n <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      wait_int(c);
      apb(0, `ADDR_SLEEP_CTRL, 0, rd);
      note(0, rd);
      brownout_enable <= 1'b1;
      brownout_low <= 1'b1;
      tick(2);
      brownout_low <= 1'b0;
      ok = 1'b1;
      repeat (8) begin @(posedge ref_clk); ok = ok & port_reset_n; end
      note(1, ok);
      for (k = 0; k < 5; k++) begin
         case (k)
            0: power_good <= 1'b0;
            1: ext_reset_n <= 1'b0;
            2: scan_reset <= 1'b1;
            3: wdt_timeout <= 1'b1;
            default: brownout_low <= 1'b1;
         endcase
         tick(12);
         note((k == 3) ? 2 : 0, {port_reset_n, int_reset_n});
         power_good <= 1'b1; ext_reset_n <= 1'b1; scan_reset <= 1'b0;
         wdt_timeout <= 1'b0; brownout_low <= 1'b0;
         wait_int(c);
         note(1, c >= ((k == 3) ? 8 : 16));
      end
      $display("reset sources test done");
      complete_run;
   end
endmodule
bind power_reset_control power_reset_checker #(.CNT_W(CNT_W)) chk (.*);
`default_nettype wire
